// ==== swf_cfg.svh ====
/*
 Constants for the serial watchdog/fail-safe controller: register codes,
 field positions, reset values and timing counts. Included by the package
 and the design modules.
*/
`ifndef SWF_CFG_SVH
`define SWF_CFG_SVH
`define SWF_WORD_BITS 16
`define SWF_ADDR_HI 14
`define SWF_ADDR_LO 12
`define SWF_TOGGLE_BIT 15
`define SWF_ADDR_OUTPUT_CTRL 3'h0
`define SWF_ADDR_OPEN_LOAD 3'h1
`define SWF_ADDR_UNUSED 3'h3
`define SWF_ADDR_CUR_LIMIT 3'h5
`define SWF_ADDR_WD_SENSE 3'h6
`define SWF_ADDR_TEST 3'h7
`define SWF_WD_SEL_HI 5
`define SWF_WD_SEL_LO 4
`define SWF_CFG_RESET 12'h000
`define SWF_BASE_TIMEOUT_US 40000
`define SWF_CLK_MHZ 100
`define SWF_BASE_TIMEOUT_CYC (`SWF_BASE_TIMEOUT_US * `SWF_CLK_MHZ)
`define SWF_OSC_DIV 100
`endif

// ==== swf_ctrl.sv ====
/*
 Serial command/status port, configuration registers and watchdog
 fail-safe mode control of a quad high-side, octal low-side switch.
 Assumes a serial master with clock idle low, data sampled on rising edge;
 fault inputs come from detectors outside this block.
*/
`timescale 1ns/10ps
`include "swf_cfg.svh"
module swf_ctrl #(
  parameter int BASE_TICKS = `SWF_BASE_TIMEOUT_CYC / `SWF_OSC_DIV,
  parameter int OSC_DIV = `SWF_OSC_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  input wire logic i_reset_pin_n,
  input wire logic i_wake,
  input wire logic i_failsafe_enable_in,
  input wire logic i_watchdog_toggle_pin,
  input wire logic [3:0] i_high_side_direct_inputs,
  input wire logic i_low_side_direct_input,
  input wire logic [11:0] i_fault_present,
  input wire logic [11:0] i_output_control_word,
  output logic [3:0] o_high_side_on,
  output logic [7:0] o_low_side_on,
  output logic [3:0] o_sense_route,
  output logic [3:0] o_hs_open_load_det_en,
  output logic [7:0] o_ls_open_load_det_en,
  output logic [3:0] o_hs_sustain_only,
  output logic [7:0] o_ls_overcurrent_latch_en,
  output swf_pkg::swf_mode_t o_mode
);
  import swf_pkg::*;

  // Two-flop synchronisers for every pin input
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [3:0] ihs_s1;
  logic [3:0] ihs_s2;
  logic ils_s1;
  logic ils_s2;
  logic [11:0] flt_s1;
  logic [11:0] flt_s2;
  always_ff @(posedge i_sys_clk) begin
    pin_s1 <= {i_cs_n, i_sclk, i_si, i_reset_pin_n, i_wake, i_failsafe_enable_in,
               i_watchdog_toggle_pin};
    pin_s2 <= pin_s1;
    ihs_s1 <= i_high_side_direct_inputs;
    ihs_s2 <= ihs_s1;
    ils_s1 <= i_low_side_direct_input;
    ils_s2 <= ils_s1;
    flt_s1 <= i_fault_present;
    flt_s2 <= flt_s1;
  end
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic rstp_s;
  logic wake_s;
  logic fsi_s;
  logic watchdog_toggle_pin_s;
  assign {cs_n_s, sclk_s, si_s, rstp_s, wake_s, fsi_s, watchdog_toggle_pin_s} = pin_s2;

  logic cs_n_d;
  logic sclk_d;
  logic rstp_d;
  logic wake_d;
  logic watchdog_toggle_pin_d;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
      rstp_d <= 1'b0;
      wake_d <= 1'b0;
      watchdog_toggle_pin_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
      rstp_d <= rstp_s;
      wake_d <= wake_s;
      watchdog_toggle_pin_d <= watchdog_toggle_pin_s;
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_fall = cs_n_d && !cs_n_s;
  assign cs_rise = !cs_n_d && cs_n_s;
  assign sclk_rise = !cs_n_s && !sclk_d && sclk_s;
  assign sclk_fall = !cs_n_s && sclk_d && !sclk_s;

  // Configuration and echo state
  swf_cfg_t open_load_detect_config;
  swf_cfg_t current_limit_config;
  swf_cfg_t watchdog_sense_config;
  logic echoed_toggle_bit;
  logic [11:0] fault_latch;
  logic [15:0] shift_out;
  logic [15:0] shift_in;
  logic [4:0] bit_cnt;
  logic word_seen;
  logic msg_valid;
  logic [2:0] msg_addr;
  logic msg_toggle;
  logic last_toggle;

  // Status word at select fall, MSB first
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      shift_out <= 16'h0000;
    end else if (cs_fall) begin
      shift_out <= {echoed_toggle_bit,
        echoed_toggle_bit ? {ihs_s2[2], ihs_s2[3], wake_s}
                          : {ihs_s2[0], ihs_s2[1], fsi_s},
        fault_latch};
    end else if (sclk_rise) begin
      shift_out <= {shift_out[14:0], si_s};
    end
  end

  // Received bits; bit 4 of the count stays zero so only the low four matter
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || cs_fall) begin
      shift_in <= 16'h0000;
      bit_cnt <= 5'h00;
      word_seen <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[14:0], si_s};
      bit_cnt <= {1'b0, bit_cnt[3:0] + 4'h1};
      if (bit_cnt[3:0] == 4'hF) begin
        word_seen <= 1'b1;
      end
    end
  end

  assign msg_valid = cs_rise && word_seen && (bit_cnt[3:0] == 4'h0);
  assign msg_addr = shift_in[`SWF_ADDR_HI:`SWF_ADDR_LO];
  assign msg_toggle = shift_in[`SWF_TOGGLE_BIT];

  // Output pin: updated on falling clock edges and through the clock low phase while selected
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || cs_rise || cs_n_s) begin
      o_so_oe_n <= 1'b1;
      o_so <= 1'b0;
    end else if (cs_fall) begin
      o_so_oe_n <= 1'b0;
      o_so <= 1'b0;
    end else begin
      o_so_oe_n <= 1'b0;
      if (sclk_fall || sclk_d == 1'b0) begin
        o_so <= shift_out[15];
      end
    end
  end

  // Register writes; reset pin low clears configuration too
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !rstp_s) begin
      open_load_detect_config <= `SWF_CFG_RESET;
      current_limit_config <= `SWF_CFG_RESET;
      watchdog_sense_config <= `SWF_CFG_RESET;
    end else if (msg_valid) begin
      unique case (msg_addr)
        `SWF_ADDR_OPEN_LOAD: open_load_detect_config <= shift_in[11:0];
        `SWF_ADDR_CUR_LIMIT: current_limit_config <= shift_in[11:0];
        `SWF_ADDR_WD_SENSE: watchdog_sense_config <= shift_in[11:0];
        default: ;
      endcase
    end
  end

  // Echo tracks toggle bit of output-control messages only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      echoed_toggle_bit <= 1'b0;
    end else if (msg_valid && msg_addr == `SWF_ADDR_OUTPUT_CTRL) begin
      echoed_toggle_bit <= msg_toggle;
    end
  end

  // Fault capture: new faults set, clear only if gone; set wins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fault_latch <= 12'h000;
    end else if (cs_rise) begin
      fault_latch <= flt_s2;
    end else if (cs_n_s) begin
      fault_latch <= fault_latch | flt_s2;
    end
  end

  // Watchdog kick: toggle of pin or of any accepted message bit
  logic kick;
  logic restart;
  logic wd_expired;
  logic wake_was_high;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_toggle <= 1'b0;
    end else if (msg_valid) begin
      last_toggle <= msg_toggle;
    end
  end
  assign kick = (watchdog_toggle_pin_s != watchdog_toggle_pin_d) || (msg_valid && msg_toggle != last_toggle);
  assign restart = (wake_s && !wake_d) || (rstp_s && !rstp_d);

  swf_watchdog #(
    .BASE_TICKS(BASE_TICKS),
    .OSC_DIV(OSC_DIV)
  ) u_wd (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    // With fail-safe enable high, wake keeps the watchdog armed while the reset pin is low
    .i_enable(fsi_s && (rstp_s || wake_s)),
    .i_restart(restart),
    .i_kick(kick),
    .i_sel(watchdog_sense_config[`SWF_WD_SEL_HI:`SWF_WD_SEL_LO]),
    .o_expired(wd_expired)
  );

  // Mode control
  swf_mode_t next_mode;
  always_comb begin
    next_mode = o_mode;
    unique case (o_mode)
      SWF_SLEEP: begin
        if (wd_expired && fsi_s) begin
          next_mode = SWF_FAILSAFE;
        end else if (rstp_s) begin
          next_mode = SWF_DEFAULT;
        end
      end
      SWF_DEFAULT, SWF_NORMAL: begin
        if (wd_expired && fsi_s) begin
          next_mode = SWF_FAILSAFE;
        end else if (!rstp_s) begin
          next_mode = SWF_SLEEP;
        end else if (msg_valid) begin
          next_mode = SWF_NORMAL;
        end
      end
      SWF_FAILSAFE: begin
        if (!fsi_s || (!rstp_s && (!wake_was_high || !wake_s))) begin
          next_mode = rstp_s ? SWF_DEFAULT : SWF_SLEEP;
        end
      end
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mode <= SWF_SLEEP;
    end else begin
      o_mode <= next_mode;
    end
  end

  // Wake seen high outside fail-safe decides the exit condition
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wake_was_high <= 1'b0;
    end else if (o_mode != SWF_FAILSAFE) begin
      wake_was_high <= wake_s;
    end
  end

  // Outputs; output-control logic lives elsewhere, so its word is an input
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_high_side_on <= 4'h0;
      o_low_side_on <= 8'h00;
    end else if (o_mode == SWF_FAILSAFE) begin
      o_high_side_on <= 4'h5;
      o_low_side_on <= 8'h00;
    end else if (o_mode == SWF_SLEEP || !rstp_s) begin
      o_high_side_on <= 4'h0;
      o_low_side_on <= 8'h00;
    end else if (o_mode == SWF_DEFAULT) begin
      o_high_side_on <= ihs_s2;
      o_low_side_on <= {8{ils_s2}};
    end else begin
      o_high_side_on <= i_output_control_word[3:0];
      o_low_side_on <= i_output_control_word[11:4];
    end
  end

  assign o_sense_route = watchdog_sense_config[3:0];
  assign o_hs_open_load_det_en = ~open_load_detect_config[3:0];
  assign o_ls_open_load_det_en = open_load_detect_config[11:4];
  assign o_hs_sustain_only = current_limit_config[3:0];
  assign o_ls_overcurrent_latch_en = current_limit_config[11:4];
endmodule : swf_ctrl

// ==== swf_ctrl_monitor.sv ====
/*
 Checker for the swf_ctrl serial port, config and mode outputs.
 Assumes binding to swf_ctrl, one 100 MHz clock, sync reset i_rst.
*/
`timescale 1ns/10ps
module swf_ctrl_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_reset_pin_n,
  input wire logic i_wake,
  input wire logic i_failsafe_enable_in,
  input wire logic o_so_oe_n,
  input wire logic [3:0] o_high_side_on,
  input wire logic [7:0] o_low_side_on,
  input wire logic [3:0] o_sense_route,
  input wire logic [3:0] o_hs_open_load_det_en,
  input wire logic [7:0] o_ls_open_load_det_en,
  input wire logic [3:0] o_hs_sustain_only,
  input wire logic [7:0] o_ls_overcurrent_latch_en,
  input wire swf_pkg::swf_mode_t o_mode
);
  import swf_pkg::*;
  wire logic [27:0] cfg_all = {o_sense_route, o_hs_open_load_det_en, o_ls_open_load_det_en,
    o_hs_sustain_only, o_ls_overcurrent_latch_en};
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Six cycles leave room for the pin synchronisers
  a_oe_off_idle: assert property (i_cs_n [*6] |-> o_so_oe_n) else $error("so on idle");
  a_oe_off_rise: assert property ($rose(i_cs_n) |-> ##[1:8] o_so_oe_n) else $error("so late");
  a_oe_on_frame: assert property (!i_cs_n [*6] |-> !o_so_oe_n) else $error("so off");
  a_failsafe_outs: assert property (o_mode == SWF_FAILSAFE [*3] |->
    o_high_side_on == 4'h5 && o_low_side_on == 8'h00) else $error("failsafe outputs");
  a_sleep_outs_off: assert property (o_mode == SWF_SLEEP [*3] |->
    o_high_side_on == 4'h0 && o_low_side_on == 8'h00) else $error("sleep outputs");
  a_fsi_disables: assert property (!i_failsafe_enable_in [*6] |->
    o_mode != SWF_FAILSAFE) else $error("failsafe with enable low");
  a_failsafe_exit: assert property ((!i_reset_pin_n && !i_wake) [*6] |->
    o_mode != SWF_FAILSAFE) else $error("failsafe not left");
  a_cfg_reset_val: assert property (!i_reset_pin_n [*6] |-> cfg_all == 28'h0F00000)
    else $error("config not cleared");
  a_cfg_hold_frame: assert property ((i_reset_pin_n && !i_cs_n) [*6] |=> $stable(cfg_all))
    else $error("config moved inside frame");
endmodule : swf_ctrl_monitor
bind swf_ctrl swf_ctrl_monitor mon_u (.i_sys_clk, .i_rst, .i_cs_n, .i_reset_pin_n, .i_wake,
  .i_failsafe_enable_in, .o_so_oe_n, .o_high_side_on, .o_low_side_on, .o_sense_route,
  .o_hs_open_load_det_en, .o_ls_open_load_det_en, .o_hs_sustain_only,
  .o_ls_overcurrent_latch_en, .o_mode);

// ==== swf_host_model.sv ====
/*
 Serial host: frames of up to 32 bits, 80 ns serial clock, MSB first.
 Assumes the caller enters xfer between frames only.
*/
`timescale 1ns/10ps
module swf_host_model (
  input wire logic i_sys_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      o_si <= tx[i];
      repeat (4) @(posedge i_sys_clk);
      o_sclk <= 1'b1;
      // Sampled late in the high phase, well after so settles
      repeat (3) @(posedge i_sys_clk);
      rx = {rx[30:0], i_so};
      @(posedge i_sys_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    repeat (6) @(posedge i_sys_clk);
  endtask : xfer
endmodule : swf_host_model

// ==== swf_pkg.sv ====
/*
 Types shared by the watchdog/fail-safe controller files.
 Assumes swf_cfg.svh is on the include path.
*/
`include "swf_cfg.svh"
package swf_pkg;
  typedef enum logic [1:0] {
    SWF_SLEEP = 2'b00,
    SWF_DEFAULT = 2'b01,
    SWF_NORMAL = 2'b10,
    SWF_FAILSAFE = 2'b11
  } swf_mode_t;
  typedef logic [11:0] swf_cfg_t;
endpackage : swf_pkg

// ==== swf_watchdog.sv ====
/*
 Watchdog counter running on a divided oscillator enable.
 Assumes toggle, restart and enable come from the same clock domain.
*/
`timescale 1ns/10ps
`include "swf_cfg.svh"
module swf_watchdog #(
  parameter int BASE_TICKS = `SWF_BASE_TIMEOUT_CYC / `SWF_OSC_DIV,
  parameter int OSC_DIV = `SWF_OSC_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_restart,
  input wire logic i_kick,
  input wire logic [1:0] i_sel,
  output logic o_expired
);
  import swf_pkg::*;
  logic [$clog2(OSC_DIV+1)-1:0] div_cnt;
  logic osc_tick;
  logic [31:0] ticks;
  logic [31:0] limit;

  // Oscillator stand-in: one enable pulse per OSC_DIV cycles
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || div_cnt == OSC_DIV[$bits(div_cnt)-1:0] - 1'b1) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign osc_tick = (div_cnt == '0);

  assign limit = 32'(BASE_TICKS) >> i_sel;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_enable || i_restart || i_kick) begin
      ticks <= '0;
    end else if (osc_tick && !o_expired) begin
      ticks <= ticks + 32'h1;
    end
  end

  // Expiry is sticky until restart or disable
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_enable || i_restart) begin
      o_expired <= 1'b0;
    end else if (ticks >= limit) begin
      o_expired <= 1'b1;
    end
  end
endmodule : swf_watchdog

// ==== tb_spi_watchdog_failsafe_ctrl.sv ====
/*
 Self-checking bench for swf_ctrl with a reference model of status and config.
 Assumes swf_host_model as serial master; watchdog shortened by parameters.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_spi_watchdog_failsafe_ctrl;
  import swf_pkg::*;
  logic i_sys_clk, i_rst, i_cs_n, i_sclk, i_si, o_so, o_so_oe_n, i_reset_pin_n, i_wake;
  logic i_failsafe_enable_in, i_watchdog_toggle_pin, i_low_side_direct_input, echo, tg, norm;
  logic [3:0] i_high_side_direct_inputs, o_high_side_on, o_sense_route;
  logic [3:0] o_hs_open_load_det_en, o_hs_sustain_only;
  logic [7:0] o_low_side_on, o_ls_open_load_det_en, o_ls_overcurrent_latch_en;
  logic [11:0] i_fault_present, i_output_control_word, lat;
  logic [11:0] cfg [8];
  logic [31:0] rx;
  swf_mode_t o_mode;
  int seed = 91797;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  // 800 ticks of 4 cycles: base timeout 3200 cycles
  swf_ctrl #(.BASE_TICKS(800), .OSC_DIV(4)) dut_u (.i_sys_clk, .i_rst, .i_cs_n, .i_sclk,
    .i_si, .o_so, .o_so_oe_n, .i_reset_pin_n, .i_wake, .i_failsafe_enable_in,
    .i_watchdog_toggle_pin, .i_high_side_direct_inputs, .i_low_side_direct_input,
    .i_fault_present, .i_output_control_word, .o_high_side_on, .o_low_side_on,
    .o_sense_route, .o_hs_open_load_det_en, .o_ls_open_load_det_en, .o_hs_sustain_only,
    .o_ls_overcurrent_latch_en, .o_mode);
  swf_host_model host_u (.i_sys_clk, .i_so(o_so), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_si(i_si));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp_cfg;
    `CHK(o_sense_route, cfg[6][3:0])
    `CHK(o_hs_open_load_det_en, ~cfg[1][3:0])
    `CHK(o_ls_open_load_det_en, cfg[1][11:4])
    `CHK(o_hs_sustain_only, cfg[5][3:0])
    `CHK(o_ls_overcurrent_latch_en, cfg[5][11:4])
  endtask : cmp_cfg
  task automatic send(input logic [2:0] a, input logic [11:0] d, input int nb);
    logic [15:0] w, exp;
    logic [31:0] tx;
    @(posedge i_sys_clk);
    i_high_side_direct_inputs <= 4'($random(seed));
    i_low_side_direct_input <= 1'($random(seed));
    i_fault_present <= 12'($random(seed));
    i_output_control_word <= 12'($random(seed));
    i_wake <= 1'($random(seed));
    i_failsafe_enable_in <= 1'($random(seed));
    i_watchdog_toggle_pin <= ~i_watchdog_toggle_pin;
    repeat (5) @(posedge i_sys_clk);
    lat = lat | i_fault_present;
    exp = {echo, echo ? {i_high_side_direct_inputs[2], i_high_side_direct_inputs[3], i_wake}
      : {i_high_side_direct_inputs[1:0], i_failsafe_enable_in}, lat};
    exp[14] = echo ? i_high_side_direct_inputs[2] : i_high_side_direct_inputs[0];
    exp[13] = echo ? i_high_side_direct_inputs[3] : i_high_side_direct_inputs[1];
    w = {~tg, a, d};
    tx = {16'($random(seed)), w};
    host_u.xfer(tx, nb, rx);
    if (nb >= 16) `CHK(rx[nb-1 -: 16], exp)
    if (nb == 32) `CHK(rx[15:0], tx[31:16])
    if (nb % 16 == 0) begin
      tg = w[15];
      if (a == 3'h0) echo = w[15];
      if (a == 3'h1 || a == 3'h5 || a == 3'h6) cfg[a] = d;
    end
    lat = i_fault_present;
    repeat (4) @(posedge i_sys_clk);
    cmp_cfg;
    if (nb % 16 == 0) norm = 1'b1;
    if (norm) begin
      `CHK(o_mode, SWF_NORMAL)
      `CHK(o_high_side_on, i_output_control_word[3:0])
      `CHK(o_low_side_on, i_output_control_word[11:4])
    end
  endtask : send
  initial begin
    #300000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {i_rst, i_wake, i_failsafe_enable_in, i_low_side_direct_input} = 4'hD;
    {i_reset_pin_n, i_watchdog_toggle_pin, echo, tg} = 4'h0;
    norm = 1'b0;
    i_high_side_direct_inputs = 4'hA;
    i_fault_present = 12'h000;
    i_output_control_word = 12'h000;
    lat = 12'h000;
    cfg = '{default: 12'h000};
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_reset_pin_n <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    cmp_cfg;
    `CHK(o_mode, SWF_DEFAULT)
    `CHK(o_high_side_on, i_high_side_direct_inputs)
    `CHK(o_low_side_on, {8{i_low_side_direct_input}})
    for (int k = 0; k < 24; k++) send(3'(k), 12'($random(seed)), 16);
    send(3'h1, 12'($random(seed)), 15);
    send(3'h5, 12'($random(seed)), 32);
    send(3'h6, 12'h030, 16);
    i_wake <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_wake <= 1'b1;
    i_failsafe_enable_in <= 1'b1;
    n = 0;
    while (o_mode !== SWF_FAILSAFE && n < 2000) begin
      @(posedge i_sys_clk);
      n++;
    end
    // Base 3200 cycles divided by 8, allowing for sync and tick slack
    `CHK(n > 360 && n < 440, 1'b1)
    // Outputs follow the mode one cycle later
    repeat (2) @(posedge i_sys_clk);
    `CHK(o_high_side_on, 4'h5)
    i_reset_pin_n <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    `CHK(o_mode, SWF_FAILSAFE)
    i_wake <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    `CHK(o_mode, SWF_SLEEP)
    cfg = '{default: 12'h000};
    cmp_cfg;
    i_reset_pin_n <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    `CHK(o_mode, SWF_DEFAULT)
    i_failsafe_enable_in <= 1'b0;
    repeat (3600) @(posedge i_sys_clk);
    `CHK(o_mode == SWF_FAILSAFE, 1'b0)
    tally_and_finish;
  end
endmodule : tb_spi_watchdog_failsafe_ctrl
